// ---- rtl/arsc_pkg.sv ----
// How it works
// - four-bit select picks status, three controls, result, four coefficients; 8 or 24 bits
// - status and result are read-only; controls and coefficients read and write
// - gain calibration overrange sets flag and pins self gain coefficient at maximum
// - rate field holds the rate of the held result or last calibration
// - over-range flag shows whether the held result was clipped high
// - under-range flag shows whether the held result was clipped low
// - modulator busy flag is high during conversion or any calibration
// - ready flag sets when a new result lands in the result register
// - unread result keeps ready; read result clears ready at next conversion start
// - result read during a running conversion clears ready right after the read
// - mains select bit one means 50Hz rates, zero means 60Hz rates
// - polarity bit one selects unipolar range, zero selects bipolar range
// - clock source bit one selects external clock, zero internal oscillator
// - reference buffer bit enables buffers, zero powers down and bypasses them
// - input buffer bit enables signal buffers, zero powers down and bypasses them
// - bipolar coding is two's complement or offset binary; unipolar always straight
// - single conversion bit does one no-latency conversion then sleeps; resets to one
// - continuous mode discards the first three results after a start
// - ready line rises zero to one at end of conversion; host times reads
// - both shift MSB first; input sampled on rising, output changes on falling
package arsc_pkg;
  localparam logic [3:0]  SEL_STATUS   = 4'h0;
  localparam logic [3:0]  SEL_SETUP    = 4'h1;
  localparam logic [3:0]  SEL_PIN_IO   = 4'h2;
  localparam logic [3:0]  SEL_GAIN_CAL = 4'h3;
  localparam logic [3:0]  SEL_RESULT   = 4'h4;
  localparam logic [3:0]  SEL_SYS_OFS  = 4'h5;
  localparam logic [3:0]  SEL_SYS_GAIN = 4'h6;
  localparam logic [3:0]  SEL_SELF_OFS = 4'h7;
  localparam logic [3:0]  SEL_SELF_GAIN = 4'h8;
  localparam logic [3:0]  SEL_LAST_WIDE8 = 4'h3;
  localparam logic [2:0]  CMD_REG_ACCESS = 3'h6;
  localparam int          CMD_TOP_MSB  = 7;
  localparam int          CMD_TOP_LSB  = 5;
  localparam int          CMD_SEL_MSB  = 4;
  localparam int          CMD_SEL_LSB  = 1;
  localparam int          CMD_RD_BIT   = 0;
  localparam logic [7:0]  SETUP_RESET  = 8'h02;
  localparam logic [7:0]  PIN_IO_RESET = 8'h0f;
  localparam logic [7:0]  GAIN_CAL_RESET = 8'h1e;
  localparam logic [7:0]  SETUP_MASK   = 8'hfe;
  localparam logic [7:0]  GAIN_CAL_MASK = 8'hfe;
  localparam logic [23:0] WORD_RESET   = 24'h000000;
  localparam logic [23:0] SELF_GAIN_MAX = 24'hffffff;
  localparam int          SETUP_MAINS  = 7;
  localparam int          SETUP_UNIPOLAR = 6;
  localparam int          SETUP_CLOCK_SOURCE_SELECT = 5;
  localparam int          SETUP_REFERENCE_BUFFER_ENABLE = 4;
  localparam int          SETUP_INPUT_BUFFER_ENABLE = 3;
  localparam int          SETUP_FORMAT = 2;
  localparam int          SETUP_SINGLE = 1;
  localparam logic [4:0]  LAST_BIT_BYTE = 5'h07;
  localparam logic [4:0]  LAST_BIT_WORD = 5'h17;
  localparam logic [1:0]  LATENCY_RESULTS = 2'h3;
  localparam int          RESULT_MSB   = 23;
  localparam int          PIN_SCLK     = 0;
  localparam int          PIN_CS_N     = 1;
  localparam int          PIN_DIN      = 2;
  localparam int          PIN_COUNT    = 3;
endpackage

// ---- rtl/arsc_pin_sync.sv ----
`timescale 1ns/1ns
module arsc_pin_sync
(
  // clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  // raw pins
  input  wire logic [arsc_pkg::PIN_COUNT-1:0] pin_i,
  // synchronised level and edges
  output logic      [arsc_pkg::PIN_COUNT-1:0] level_o,
  output logic      [arsc_pkg::PIN_COUNT-1:0] rise_o,
  output logic      [arsc_pkg::PIN_COUNT-1:0] fall_o
);
  logic [arsc_pkg::PIN_COUNT-1:0] meta;
  logic [arsc_pkg::PIN_COUNT-1:0] sync;
  logic [arsc_pkg::PIN_COUNT-1:0] prev;
  logic [arsc_pkg::PIN_COUNT-1:0] next_meta;
  logic [arsc_pkg::PIN_COUNT-1:0] next_sync;
  logic [arsc_pkg::PIN_COUNT-1:0] next_prev;

  // idle pins reset high: chip select and clock idle high on this link
  always_comb
  begin
    next_meta = pin_i;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      meta <= '1;
      sync <= '1;
      prev <= '1;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level_o = sync;
  assign rise_o  = sync & ~prev;
  assign fall_o  = ~sync & prev;
endmodule

// ---- rtl/arsc_reg_status_ctrl.sv ----
`timescale 1ns/1ns
module arsc_reg_status_ctrl
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // serial link pins
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        din_i,
  output logic             rdy_dout_o,
  output logic             rdy_dout_oe_o,
  // converter core events
  input  wire logic        core_busy_i,
  input  wire logic        core_conv_start_i,
  input  wire logic        core_done_i,
  input  wire logic [23:0] core_result_i,
  input  wire logic        core_over_i,
  input  wire logic        core_under_i,
  input  wire logic [2:0]  core_rate_i,
  input  wire logic        core_cal_done_i,
  input  wire logic        core_cal_over_i,
  // control settings
  output logic             mains_frequency_select_o,
  output logic             unipolar_select_o,
  output logic             clock_source_select_o,
  output logic             reference_buffer_enable_o,
  output logic             input_buffer_enable_o,
  output logic             format_select_o,
  output logic             single_conversion_select_o,
  output logic [7:0]       pin_io_control_byte_o,
  output logic [7:0]       gain_calibration_control_byte_o,
  output logic [23:0]      system_offset_coefficient_o,
  output logic [23:0]      system_gain_coefficient_o,
  output logic [23:0]      self_cal_offset_coefficient_o,
  output logic [23:0]      self_cal_gain_coefficient_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_READ, ST_WRITE, ST_SKIP} arsc_state_t;

  function automatic logic [4:0] last_bit(input logic [3:0] sel);
    last_bit = (sel <= arsc_pkg::SEL_LAST_WIDE8) ? arsc_pkg::LAST_BIT_BYTE
                                                 : arsc_pkg::LAST_BIT_WORD;
  endfunction

  // raw core result is two's complement
  function automatic logic [23:0] code_result(input logic [23:0] raw,
                                              input logic unipolar,
                                              input logic offset_bin);
    code_result = raw;
    if (unipolar || offset_bin)
      code_result[arsc_pkg::RESULT_MSB] = ~raw[arsc_pkg::RESULT_MSB];
  endfunction

  logic [arsc_pkg::PIN_COUNT-1:0] pin_lvl;
  logic [arsc_pkg::PIN_COUNT-1:0] pin_rise;
  logic [arsc_pkg::PIN_COUNT-1:0] pin_fall;

  arsc_pin_sync u_sync
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({din_i, cs_n_i, sclk_i}),
    .level_o   (pin_lvl),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  logic cs_act;
  logic sck_rise;
  logic sck_fall;
  logic din_s;
  assign cs_act   = ~pin_lvl[arsc_pkg::PIN_CS_N];
  assign sck_rise = cs_act & pin_rise[arsc_pkg::PIN_SCLK];
  assign sck_fall = cs_act & pin_fall[arsc_pkg::PIN_SCLK];
  assign din_s    = pin_lvl[arsc_pkg::PIN_DIN];

  // link state
  arsc_state_t state;
  arsc_state_t next_state;
  logic [4:0]  cnt;
  logic [4:0]  next_cnt;
  logic [23:0] shreg;
  logic [23:0] next_shreg;
  logic [3:0]  sel;
  logic [3:0]  next_sel;
  logic        dout;
  logic        next_dout;
  logic        wr_commit;
  logic        data_read_done;
  logic [7:0]  cmd_byte;
  logic [23:0] rd_value;

  // register state
  logic [7:0]  setup;
  logic [7:0]  next_setup;
  logic [7:0]  pin_io;
  logic [7:0]  next_pin_io;
  logic [7:0]  gain_cal;
  logic [7:0]  next_gain_cal;
  logic [23:0] sys_ofs;
  logic [23:0] next_sys_ofs;
  logic [23:0] sys_gain;
  logic [23:0] next_sys_gain;
  logic [23:0] self_ofs;
  logic [23:0] next_self_ofs;
  logic [23:0] self_gain;
  logic [23:0] next_self_gain;
  logic [23:0] result;
  logic [23:0] next_result;
  logic        cal_over;
  logic        next_cal_over;
  logic [2:0]  rate;
  logic [2:0]  next_rate;
  logic        over;
  logic        next_over;
  logic        under;
  logic        next_under;
  logic        rdy;
  logic        next_rdy;
  logic        read_seen;
  logic        next_read_seen;
  logic [1:0]  discard;
  logic [1:0]  next_discard;
  logic        accept;
  logic [7:0]  status_byte;

  assign status_byte = {cal_over, rate, over, under, core_busy_i, rdy};
  assign cmd_byte    = {shreg[6:0], din_s};

  always_comb
  begin
    rd_value = 24'h000000;
    unique case (sel)
      arsc_pkg::SEL_STATUS:    rd_value = {status_byte, 16'h0000};
      arsc_pkg::SEL_SETUP:     rd_value = {setup, 16'h0000};
      arsc_pkg::SEL_PIN_IO:    rd_value = {pin_io, 16'h0000};
      arsc_pkg::SEL_GAIN_CAL:  rd_value = {gain_cal, 16'h0000};
      arsc_pkg::SEL_RESULT:    rd_value = result;
      arsc_pkg::SEL_SYS_OFS:   rd_value = sys_ofs;
      arsc_pkg::SEL_SYS_GAIN:  rd_value = sys_gain;
      arsc_pkg::SEL_SELF_OFS:  rd_value = self_ofs;
      arsc_pkg::SEL_SELF_GAIN: rd_value = self_gain;
      default:                 rd_value = 24'h000000;
    endcase
  end

  // serial framing: command byte, then data bits MSB first
  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_shreg     = shreg;
    next_sel       = sel;
    next_dout      = dout;
    wr_commit      = 1'b0;
    data_read_done = 1'b0;
    if (!cs_act)
    begin
      next_state = ST_IDLE;
      next_cnt   = 5'h00;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          next_state = ST_CMD;
          next_cnt   = 5'h00;
        end
        ST_CMD:
        begin
          if (sck_rise)
          begin
            next_shreg = {shreg[22:0], din_s};
            next_cnt   = cnt + 5'h01;
            if (cnt == arsc_pkg::LAST_BIT_BYTE)
            begin
              next_cnt = 5'h00;
              next_sel = cmd_byte[arsc_pkg::CMD_SEL_MSB:arsc_pkg::CMD_SEL_LSB];
              if (cmd_byte[arsc_pkg::CMD_TOP_MSB:arsc_pkg::CMD_TOP_LSB]
                  != arsc_pkg::CMD_REG_ACCESS
                  || next_sel > arsc_pkg::SEL_SELF_GAIN)
                next_state = ST_SKIP;
              else if (cmd_byte[arsc_pkg::CMD_RD_BIT])
                next_state = ST_READ;
              else
                next_state = ST_WRITE;
            end
          end
        end
        ST_READ:
        begin
          if (cnt == 5'h00 && sck_fall)
          begin
            next_dout  = rd_value[arsc_pkg::RESULT_MSB];
            next_shreg = {rd_value[22:0], 1'b0};
          end
          else if (sck_fall)
          begin
            next_dout  = shreg[arsc_pkg::RESULT_MSB];
            next_shreg = {shreg[22:0], 1'b0};
          end
          if (sck_rise)
          begin
            next_cnt = cnt + 5'h01;
            if (cnt == last_bit(sel))
            begin
              next_state     = ST_CMD;
              next_cnt       = 5'h00;
              data_read_done = (sel == arsc_pkg::SEL_RESULT);
            end
          end
        end
        ST_WRITE:
        begin
          if (sck_rise)
          begin
            next_shreg = {shreg[22:0], din_s};
            next_cnt   = cnt + 5'h01;
            if (cnt == last_bit(sel))
            begin
              wr_commit  = 1'b1;
              next_state = ST_CMD;
              next_cnt   = 5'h00;
            end
          end
        end
        ST_SKIP:
        begin
          next_state = ST_SKIP;
        end
      endcase
    end
    if (state != ST_READ || !cs_act)
      next_dout = rdy;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      cnt   <= 5'h00;
      shreg <= 24'h000000;
      sel   <= 4'h0;
      dout  <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      shreg <= next_shreg;
      sel   <= next_sel;
      dout  <= next_dout;
    end
  end

  // register file, status flags and ready tracking
  always_comb
  begin
    next_setup     = setup;
    next_pin_io    = pin_io;
    next_gain_cal  = gain_cal;
    next_sys_ofs   = sys_ofs;
    next_sys_gain  = sys_gain;
    next_self_ofs  = self_ofs;
    next_self_gain = self_gain;
    next_result    = result;
    next_cal_over  = cal_over;
    next_rate      = rate;
    next_over      = over;
    next_under     = under;
    next_rdy       = rdy;
    next_read_seen = read_seen;
    next_discard   = discard;
    accept         = 1'b0;
    if (wr_commit)
    begin
      // status and result selects fall through unchanged
      unique case (sel)
        arsc_pkg::SEL_SETUP:     next_setup = next_shreg[7:0] & arsc_pkg::SETUP_MASK;
        arsc_pkg::SEL_PIN_IO:    next_pin_io = next_shreg[7:0];
        arsc_pkg::SEL_GAIN_CAL:  next_gain_cal = next_shreg[7:0] & arsc_pkg::GAIN_CAL_MASK;
        arsc_pkg::SEL_SYS_OFS:   next_sys_ofs = next_shreg;
        arsc_pkg::SEL_SYS_GAIN:  next_sys_gain = next_shreg;
        arsc_pkg::SEL_SELF_OFS:  next_self_ofs = next_shreg;
        arsc_pkg::SEL_SELF_GAIN: next_self_gain = next_shreg;
        default:                 next_result = result;
      endcase
    end
    if (core_cal_done_i)
    begin
      next_cal_over = core_cal_over_i;
      next_rate     = core_rate_i;
      if (core_cal_over_i)
        next_self_gain = arsc_pkg::SELF_GAIN_MAX;
    end
    if (data_read_done)
    begin
      if (core_busy_i)
        next_rdy = 1'b0;
      else
        next_read_seen = 1'b1;
    end
    if (core_conv_start_i)
    begin
      if (read_seen)
        next_rdy = 1'b0;
      next_read_seen = 1'b0;
      next_discard   = setup[arsc_pkg::SETUP_SINGLE] ? 2'h0 : arsc_pkg::LATENCY_RESULTS;
    end
    if (core_done_i)
    begin
      if (discard != 2'h0)
        next_discard = discard - 2'h1;
      else
        accept = 1'b1;
    end
    if (accept)
    begin
      next_result = code_result(core_result_i, setup[arsc_pkg::SETUP_UNIPOLAR],
                                setup[arsc_pkg::SETUP_FORMAT]);
      next_over      = core_over_i;
      next_under     = core_under_i;
      next_rate      = core_rate_i;
      next_rdy       = 1'b1;
      next_read_seen = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      setup     <= arsc_pkg::SETUP_RESET;
      pin_io    <= arsc_pkg::PIN_IO_RESET;
      gain_cal  <= arsc_pkg::GAIN_CAL_RESET;
      sys_ofs   <= arsc_pkg::WORD_RESET;
      sys_gain  <= arsc_pkg::WORD_RESET;
      self_ofs  <= arsc_pkg::WORD_RESET;
      self_gain <= arsc_pkg::WORD_RESET;
      result    <= arsc_pkg::WORD_RESET;
      cal_over  <= 1'b0;
      rate      <= 3'h0;
      over      <= 1'b0;
      under     <= 1'b0;
      rdy       <= 1'b0;
      read_seen <= 1'b0;
      discard   <= 2'h0;
    end
    else
    begin
      setup     <= next_setup;
      pin_io    <= next_pin_io;
      gain_cal  <= next_gain_cal;
      sys_ofs   <= next_sys_ofs;
      sys_gain  <= next_sys_gain;
      self_ofs  <= next_self_ofs;
      self_gain <= next_self_gain;
      result    <= next_result;
      cal_over  <= next_cal_over;
      rate      <= next_rate;
      over      <= next_over;
      under     <= next_under;
      rdy       <= next_rdy;
      read_seen <= next_read_seen;
      discard   <= next_discard;
    end
  end

  assign rdy_dout_o                      = dout;
  assign rdy_dout_oe_o                   = cs_act;
  assign mains_frequency_select_o        = setup[arsc_pkg::SETUP_MAINS];
  assign unipolar_select_o               = setup[arsc_pkg::SETUP_UNIPOLAR];
  assign clock_source_select_o           = setup[arsc_pkg::SETUP_CLOCK_SOURCE_SELECT];
  assign reference_buffer_enable_o       = setup[arsc_pkg::SETUP_REFERENCE_BUFFER_ENABLE];
  assign input_buffer_enable_o           = setup[arsc_pkg::SETUP_INPUT_BUFFER_ENABLE];
  assign format_select_o                 = setup[arsc_pkg::SETUP_FORMAT];
  assign single_conversion_select_o      = setup[arsc_pkg::SETUP_SINGLE];
  assign pin_io_control_byte_o           = pin_io;
  assign gain_calibration_control_byte_o = gain_cal;
  assign system_offset_coefficient_o     = sys_ofs;
  assign system_gain_coefficient_o       = sys_gain;
  assign self_cal_offset_coefficient_o   = self_ofs;
  assign self_cal_gain_coefficient_o     = self_gain;

  sequence s_cont_start;
    core_conv_start_i && !setup[arsc_pkg::SETUP_SINGLE] && !core_done_i;
  endsequence
  sequence s_early_done;
    core_done_i && !core_conv_start_i && !data_read_done && discard != 2'h0;
  endsequence

  chk_latency_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_cont_start |=> discard == arsc_pkg::LATENCY_RESULTS)
    else $error("latency count not loaded at continuous start");
  chk_latency_discard: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_early_done |=> $stable(rdy) && $stable(result))
    else $error("result accepted inside latency window");
  chk_rdy_on_result: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept |=> rdy && result == $past(next_result))
    else $error("ready not set on new result");
  chk_rdy_held_unread: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rdy && !read_seen && !data_read_done && core_conv_start_i |=> rdy)
    else $error("unread ready lost at conversion start");
  chk_rdy_clear_busy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    data_read_done && core_busy_i && !accept |=> !rdy)
    else $error("ready not cleared after read during conversion");
  chk_ro_result_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_commit && sel == arsc_pkg::SEL_RESULT && !accept |=> $stable(result))
    else $error("write changed result register");
  chk_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    setup[0] == 1'b0 && gain_cal[0] == 1'b0)
    else $error("reserved bit reads one");
  chk_clip_flags: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept |=> over == $past(core_over_i) && under == $past(core_under_i))
    else $error("clip flags do not follow result");
  chk_cal_saturate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    core_cal_done_i && core_cal_over_i |=> cal_over && self_gain == arsc_pkg::SELF_GAIN_MAX)
    else $error("overrange calibration not saturated");
  chk_dout_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cs_act && state == ST_CMD && $past(state) == ST_CMD |-> rdy_dout_o == $past(rdy))
    else $error("ready line does not show ready flag");
  chk_decode_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state == ST_CMD && sck_rise && cnt == arsc_pkg::LAST_BIT_BYTE
    && cmd_byte == 8'hc1 |=> state == ST_READ && sel == arsc_pkg::SEL_STATUS)
    else $error("status read command not decoded");
endmodule

// ---- sim/arsc_host_model.sv ----
`timescale 1ns/1ns
module arsc_host_model
(
  // timing reference
  input  wire logic sys_clk_i,
  // link pins
  input  wire logic rdy_dout_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o
);
  localparam int HALF_CYCLES = 6;

  initial
  begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end

  task automatic half_wait();
    repeat (HALF_CYCLES) @(negedge sys_clk_i);
  endtask

  // data goes out on the falling edge, dout is taken on the rising edge
  task automatic shift(input logic [23:0] wdata, input int nbits, output logic [23:0] rdata);
    rdata = 24'h000000;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      din_o  = wdata[i];
      half_wait();
      sclk_o = 1'b1;
      rdata  = {rdata[22:0], rdy_dout_i};
      half_wait();
    end
  endtask

  // released data line shows the inverse of its last value
  task automatic select_low(input logic low);
    cs_n_o = ~low;
    if (!low)
      din_o = ~din_o;
    half_wait();
  endtask

  task automatic access(input logic [3:0] sel, input logic rd, input logic [23:0] wdata,
                        output logic [23:0] rdata);
    logic [23:0] unused;
    int          nbits;
    nbits = (sel > 4'h3) ? 24 : 8;
    select_low(1'b1);
    shift({16'h0000, 3'b110, sel, rd}, 8, unused);
    shift(wdata, nbits, rdata);
    select_low(1'b0);
  endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  logic        sys_clk_i;
  logic        rst_i;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic        rdy_dout;
  logic        rdy_dout_oe;
  logic        core_busy;
  logic        core_conv_start;
  logic        core_done;
  logic        core_cal_done;
  logic        core_over;
  logic        core_under;
  logic        core_cal_over;
  logic [2:0]  core_rate;
  logic [23:0] core_result;
  wire [6:0]   setup_bits;
  logic [7:0]  pin_io;
  logic [7:0]  gain_cal;
  wire [23:0]  coef [4];
  logic [23:0] reset_tab [9];
  int          failures;
  int          comparisons;

  arsc_reg_status_ctrl arsc_reg_status_ctrl_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .rdy_dout_o(rdy_dout),
    .rdy_dout_oe_o(rdy_dout_oe), .core_busy_i(core_busy), .core_conv_start_i(core_conv_start),
    .core_done_i(core_done), .core_result_i(core_result), .core_over_i(core_over),
    .core_under_i(core_under), .core_rate_i(core_rate), .core_cal_done_i(core_cal_done),
    .core_cal_over_i(core_cal_over), .mains_frequency_select_o(setup_bits[6]),
    .unipolar_select_o(setup_bits[5]), .clock_source_select_o(setup_bits[4]),
    .reference_buffer_enable_o(setup_bits[3]), .input_buffer_enable_o(setup_bits[2]),
    .format_select_o(setup_bits[1]), .single_conversion_select_o(setup_bits[0]),
    .pin_io_control_byte_o(pin_io), .gain_calibration_control_byte_o(gain_cal),
    .system_offset_coefficient_o(coef[0]), .system_gain_coefficient_o(coef[1]),
    .self_cal_offset_coefficient_o(coef[2]), .self_cal_gain_coefficient_o(coef[3]));

  arsc_host_model arsc_host_model_i (.sys_clk_i(sys_clk_i), .rdy_dout_i(rdy_dout),
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    comparisons++;
    if (seen !== want)
    begin
      failures++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic rdreg(input logic [3:0] sel, input logic [23:0] want);
    logic [23:0] got;
    arsc_host_model_i.access(sel, 1'b1, 24'h000000, got);
    check(got, want);
  endtask

  task automatic wrreg(input logic [3:0] sel, input logic [23:0] val);
    logic [23:0] got;
    arsc_host_model_i.access(sel, 1'b0, val, got);
  endtask

  // kind: 0 conversion start, 1 conversion done, 2 calibration done
  task automatic core_event(input int kind, input logic [23:0] res, input logic [2:0] rate,
                            input logic flag_a, input logic flag_b);
    @(negedge sys_clk_i);
    core_conv_start = (kind == 0);
    core_done = (kind == 1);
    core_cal_done = (kind == 2);
    core_result = res;
    core_rate = rate;
    core_over = flag_a;
    core_under = flag_b;
    core_cal_over = flag_a;
    @(negedge sys_clk_i);
    core_conv_start = 1'b0;
    core_done = 1'b0;
    core_cal_done = 1'b0;
    repeat (2) @(negedge sys_clk_i);
  endtask

  task automatic test_reset();
    reset_tab = '{24'h00, 24'h02, 24'h0f, 24'h1e, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
    check(rdy_dout_oe, 1'b0);
    check(setup_bits, 7'h01);
    for (int s = 0; s < 9; s++)
      rdreg(s[3:0], reset_tab[s]);
    $display("test_reset finished");
  endtask

  task automatic test_write();
    wrreg(4'h1, 24'hff);
    rdreg(4'h1, 24'hfe);
    check(setup_bits, 7'h7f);
    wrreg(4'h1, 24'h00);
    check(setup_bits, 7'h00);
    wrreg(4'h2, 24'h5a);
    rdreg(4'h2, 24'h5a);
    wrreg(4'h3, 24'h37);
    rdreg(4'h3, 24'h36);
    check({pin_io, gain_cal}, 16'h5a36);
    for (int s = 5; s < 9; s++)
    begin
      wrreg(s[3:0], 24'ha5c300 | 24'(s));
      rdreg(s[3:0], 24'ha5c300 | 24'(s));
      check(coef[s-5], 24'ha5c300 | 24'(s));
    end
    // select beyond the last register is refused for the whole frame
    wrreg(4'h9, 24'h123456);
    check(coef[0], 24'ha5c305);
    wrreg(4'h0, 24'hff);
    wrreg(4'h4, 24'habcdef);
    rdreg(4'h0, 24'h00);
    rdreg(4'h4, 24'h000000);
    wrreg(4'h1, 24'h02);
    $display("test_write finished");
  endtask

  task automatic test_status();
    core_busy = 1'b1;
    core_event(1, 24'h123456, 3'h5, 1'b1, 1'b0);
    rdreg(4'h0, 24'h5b);
    rdreg(4'h4, 24'h123456);
    rdreg(4'h0, 24'h5a);
    core_busy = 1'b0;
    core_event(1, 24'h800000, 3'h2, 1'b0, 1'b1);
    rdreg(4'h0, 24'h25);
    rdreg(4'h4, 24'h800000);
    rdreg(4'h0, 24'h25);
    core_event(0, 24'h0, 3'h0, 1'b0, 1'b0);
    rdreg(4'h0, 24'h24);
    core_event(2, 24'h0, 3'h1, 1'b1, 1'b0);
    rdreg(4'h0, 24'h94);
    check(coef[3], 24'hffffff);
    $display("test_status finished");
  endtask

  task automatic test_continuous();
    wrreg(4'h1, 24'h40);
    core_event(0, 24'h0, 3'h0, 1'b0, 1'b0);
    arsc_host_model_i.select_low(1'b1);
    check({rdy_dout_oe, rdy_dout}, 2'b10);
    for (int n = 0; n < 3; n++)
    begin
      core_event(1, 24'h000010, 3'h3, 1'b0, 1'b0);
      check(rdy_dout, 1'b0);
    end
    core_event(1, 24'h000010, 3'h3, 1'b0, 1'b0);
    check(rdy_dout, 1'b1);
    arsc_host_model_i.select_low(1'b0);
    rdreg(4'h4, 24'h800010);
    wrreg(4'h1, 24'h06);
    core_event(1, 24'h000001, 3'h3, 1'b0, 1'b0);
    rdreg(4'h4, 24'h800001);
    core_event(1, 24'h000002, 3'h3, 1'b0, 1'b0);
    core_event(0, 24'h0, 3'h0, 1'b0, 1'b0);
    rdreg(4'h0, 24'hb1);
    $display("test_continuous finished");
  endtask

  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    // tests take roughly 12,000 clock cycles
    #400000;
    failures++;
    close_out();
  end

  initial
  begin
    failures = 0;
    comparisons = 0;
    rst_i = 1'b1;
    core_busy = 1'b0;
    core_conv_start = 1'b0;
    core_done = 1'b0;
    core_cal_done = 1'b0;
    core_over = 1'b0;
    core_under = 1'b0;
    core_cal_over = 1'b0;
    core_rate = 3'h0;
    core_result = 24'h000000;
    repeat (10) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    test_reset();
    test_write();
    test_status();
    test_continuous();
    close_out();
  end
endmodule
